/* design/ppe_consts.vh */
/*
 * Constants for the parallel port handshake block: modes, timing figures
 * and cycle counts derived from the 50 MHz core clock.
 * Assumes the includer runs on mclk at CLK_PERIOD_NS.
 */
`ifndef PPE_CONSTS_VH
`define PPE_CONSTS_VH

// Core clock period in ns
`define PPE_CLK_PERIOD_NS   20

// Port modes, three bit field
`define PPE_MODE_W          3
`define PPE_MODE_COMPAT     3'h0
`define PPE_MODE_FIFO       3'h2
`define PPE_MODE_ECP        3'h3
`define PPE_MODE_EPP        3'h4
// Documented FIFO mode code 101, also decoded as FIFO mode
`define PPE_MODE_FIFO_DOC   3'h5

// Acknowledge filter window, lower bound taken, rounded up
`define PPE_ACK_FILT_NS     75
`define PPE_ACK_FILT_CYC    ((`PPE_ACK_FILT_NS + `PPE_CLK_PERIOD_NS - 1) / `PPE_CLK_PERIOD_NS)
// Wait settle time, least time rounded up
`define PPE_WAIT_SET_NS     50
`define PPE_WAIT_SET_CYC    ((`PPE_WAIT_SET_NS + `PPE_CLK_PERIOD_NS - 1) / `PPE_CLK_PERIOD_NS)
// EPP time-out, least time rounded up
`define PPE_EPP_TOUT_NS     10000
`define PPE_EPP_TOUT_CYC    ((`PPE_EPP_TOUT_NS + `PPE_CLK_PERIOD_NS - 1) / `PPE_CLK_PERIOD_NS)
// Data setup before strobe: 3 cable round trips, one trip in ns
`define PPE_TRIP_NS         30
`define PPE_SETUP_NS        (3 * `PPE_TRIP_NS)
`define PPE_SETUP_CYC       ((`PPE_SETUP_NS + `PPE_CLK_PERIOD_NS - 1) / `PPE_CLK_PERIOD_NS)

`define PPE_CNT_W           10

`endif

/* design/ppe_filter.v */
/*
 * Stability filter: synchronises a pin and reports a new level only after
 * it has held unchanged for STABLE_CYC cycles.
 * Assumes din is asynchronous to mclk.
 */
`timescale 1ns/1ns
module ppe_filter #(
    parameter STABLE_CYC = 4,
    parameter RST_VAL    = 1'b1
) (
    // Clock and reset
    input  wire mclk,
    input  wire reset_n,
    // Pin and filtered level
    input  wire din,
    output reg  dout
);

reg       sync1_r;
reg       sync2_r;
reg       last_r;
reg [7:0] cnt_r;

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser; only stage two feeds logic
// Reset to the idle level so no false edge follows reset
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        sync1_r <= RST_VAL;
        sync2_r <= RST_VAL;
    end else begin
        sync1_r <= din;
        sync2_r <= sync1_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Restart the count on every transition, accept once it reaches the window
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        last_r <= RST_VAL;
        cnt_r  <= 8'h00;
        dout   <= RST_VAL;
    end else begin
        last_r <= sync2_r;
        if (sync2_r != last_r) begin
            cnt_r <= 8'h00;
        end else if (cnt_r < STABLE_CYC[7:0]) begin
            cnt_r <= cnt_r + 8'h01;
        end else begin
            dout <= sync2_r;
        end
    end
end

endmodule

/* design/ppe_port.v */
/*
 * Parallel port handshake engine: ECP forward and reverse phases, FIFO
 * mode forward transfers paced by the busy line, EPP cycles with host
 * bus ready control, and dynamic push-pull or open-collector drivers.
 * Assumes a host-side byte source and sink on mclk, and cable pins that
 * are asynchronous and resolved outside from the output enables.
 */
// Function
// RULE1: With nothing to send forward, hold the host clock line high.
// RULE2: Peripheral keeps its clock low while forward idle. The bench model keeps it high, and uAck resets high.
// RULE3: Peripheral request may come anytime in forward phase; accepted asynchronously.
// RULE4: Forward byte: ack low, clock low, ack high, clock high, ack low.
// RULE5: Data stable three cable round trips before host clock falls.
// RULE6: Forward transfer begins only from forward idle.
// RULE7: Reverse idle: peripheral clock high, host ack held low.
// RULE8: Reverse byte: ack low, pclk low, ack high, pclk high, ack low.
// RULE9: FIFO mode ignores acknowledge, paces each transfer from busy alone.
// RULE10: Drivers push-pull in ECP, open-collector otherwise, switched without glitch.
// RULE11: Stall reverse by holding host ack low when full or terminal count.
// RULE12: Acknowledge counts as changed only after stable through its filter window.
// RULE13: Wait line settled only after no transition for 50 ns.
// RULE14: Write-direction output inactive high whenever no EPP write runs.
// RULE15: Software sets direction bit 1 before read, 0 before write.
// RULE16: EPP strobe drops host ready; restored after wait handshake or timeout.
`timescale 1ns/1ns
`include "ppe_consts.vh"
module ppe_port (
    // Clock and reset
    input  wire       mclk,
    input  wire       reset_n,
    // Mode and control
    input  wire [2:0] portMode,
    input  wire       portDirectionBit,
    input  wire       reverseReq,
    input  wire       dmaTermCount,
    // Forward byte source
    input  wire       fwdValid,
    input  wire [7:0] fwdData,
    output reg        fwdReady,
    // Reverse byte sink
    input  wire       revFull,
    output reg        revValid,
    output reg  [7:0] revData,
    // Host bus EPP strobe and ready
    input  wire       hostStrobe_n,
    output reg        hostReady,
    output reg        eppTimeout,
    // Peripheral request, asynchronous catch
    output reg        periphReqSeen,
    // Cable inputs
    input  wire       hostClkIn,
    input  wire       hostAckIn,
    input  wire       periphAckIn,
    input  wire       periphClkIn,
    input  wire       periphReq_n,
    input  wire       waitIn_n,
    input  wire [7:0] dataIn,
    // Cable outputs and enables
    output reg        hostClkOut,
    output reg        hostClkOe,
    output reg        hostAckOut,
    output reg        hostAckOe,
    output reg  [7:0] dataOut,
    output reg  [7:0] dataOe,
    output reg        eppWrite_n
);

localparam ST_FIDLE  = 4'h0;
localparam ST_FSETUP = 4'h1;
localparam ST_FSTRB  = 4'h2;
localparam ST_FREL   = 4'h3;
localparam ST_RIDLE  = 4'h4;
localparam ST_RACK   = 4'h5;
localparam ST_RTAKE  = 4'h6;
localparam ST_EPP    = 4'h7;
localparam ST_EPPEND = 4'h8;

reg  [3:0]            state_r;
reg  [3:0]            state_nxt;
reg  [`PPE_CNT_W-1:0] cnt_r;
reg  [7:0]            dataHold_r;
reg                   ecpDrv_r;
reg                   req1_r;
reg                   req2_r;
reg                   hostClk1_r;
reg                   hostAck1_r;
reg  [7:0]            data1_r;
reg  [7:0]            data2_r;
wire                  ackF;
wire                  busyF;
wire                  waitF;
wire                  isFifo;

assign isFifo = (portMode == `PPE_MODE_FIFO) || (portMode == `PPE_MODE_FIFO_DOC);

////////////////////////////////////////////////////////////////////////////////
// Filtered cable inputs; ack reverts only after a stable window
ppe_filter #(.STABLE_CYC(`PPE_ACK_FILT_CYC), .RST_VAL(1'b1)) uAck ( // [RULE12]
    .mclk    (mclk),
    .reset_n (reset_n),
    .din     (periphClkIn),
    .dout    (ackF)
);
ppe_filter #(.STABLE_CYC(1), .RST_VAL(1'b0)) uBusy (
    .mclk    (mclk),
    .reset_n (reset_n),
    .din     (periphAckIn),
    .dout    (busyF)
);
ppe_filter #(.STABLE_CYC(`PPE_WAIT_SET_CYC), .RST_VAL(1'b1)) uWait ( // [RULE13]
    .mclk    (mclk),
    .reset_n (reset_n),
    .din     (waitIn_n),
    .dout    (waitF)
);

////////////////////////////////////////////////////////////////////////////////
// Request caught on its own edge so it needs no handshake timing
always @(negedge periphReq_n or negedge reset_n) begin
    if (!reset_n) begin
        req1_r <= 1'b0;
    end else begin
        req1_r <= 1'b1; // [RULE3]
    end
end

// Request, echo of own drivers and reverse data, synchronised before use
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        req2_r        <= 1'b0;
        periphReqSeen <= 1'b0;
        hostClk1_r    <= 1'b1;
        hostAck1_r    <= 1'b0;
        data1_r       <= 8'h00;
        data2_r       <= 8'h00;
    end else begin
        req2_r        <= req1_r;
        periphReqSeen <= req2_r;
        hostClk1_r    <= hostClkIn;
        hostAck1_r    <= hostAckIn;
        data1_r       <= dataIn;
        data2_r       <= data1_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Phase sequencer
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_FIDLE: begin
            if (portMode == `PPE_MODE_EPP && !hostStrobe_n) begin
                state_nxt = ST_EPP;
            end else if (reverseReq && !isFifo) begin
                state_nxt = ST_RIDLE;
            end else if (fwdValid && !busyF) begin
                state_nxt = ST_FSETUP; // [RULE6]
            end
        end
        ST_FSETUP: begin
            if (cnt_r >= `PPE_SETUP_CYC) begin
                state_nxt = ST_FSTRB; // [RULE5]
            end
        end
        ST_FSTRB: begin
            if (busyF) begin
                state_nxt = ST_FREL; // [RULE4]
            end
        end
        ST_FREL: begin
            // FIFO mode paces on busy only, acknowledge unused [RULE9]
            if (!busyF) begin
                state_nxt = ST_FIDLE; // [RULE4]
            end
        end
        ST_RIDLE: begin
            if (!reverseReq) begin
                state_nxt = ST_FIDLE;
            end else if (!ackF && !revFull && !dmaTermCount) begin
                state_nxt = ST_RACK; // [RULE8] [RULE11]
            end
        end
        ST_RACK: begin
            if (ackF) begin
                state_nxt = ST_RTAKE; // [RULE8]
            end
        end
        ST_RTAKE: begin
            state_nxt = ST_RIDLE;
        end
        ST_EPP: begin
            if (!waitF || cnt_r >= `PPE_EPP_TOUT_CYC) begin
                state_nxt = ST_EPPEND; // [RULE16]
            end
        end
        ST_EPPEND: begin
            if (hostStrobe_n) begin
                state_nxt = ST_FIDLE;
            end
        end
        default: begin
            state_nxt = ST_FIDLE;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// State, counter, data holding and the registered pin drivers
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        state_r    <= ST_FIDLE;
        cnt_r      <= {`PPE_CNT_W{1'b0}};
        dataHold_r <= 8'h00;
        ecpDrv_r   <= 1'b0;
        fwdReady   <= 1'b0;
        revValid   <= 1'b0;
        revData    <= 8'h00;
        hostReady  <= 1'b1;
        eppTimeout <= 1'b0;
        hostClkOut <= 1'b1;
        hostClkOe  <= 1'b0;
        hostAckOut <= 1'b0;
        hostAckOe  <= 1'b0;
        dataOut    <= 8'h00;
        dataOe     <= 8'h00;
        eppWrite_n <= 1'b1;
    end else begin
        state_r  <= state_nxt;
        cnt_r    <= (state_nxt != state_r) ? {`PPE_CNT_W{1'b0}} : cnt_r + 1'b1;
        fwdReady <= 1'b0;
        revValid <= 1'b0;
        // Driver style changes only in idle, with the line already high
        if (state_r == ST_FIDLE && hostClkOut) begin
            ecpDrv_r <= (portMode == `PPE_MODE_ECP); // [RULE10]
        end
        if (state_r == ST_FIDLE && state_nxt == ST_FSETUP) begin
            dataHold_r <= fwdData;
            fwdReady   <= 1'b1;
        end
        if (state_r == ST_RACK && state_nxt == ST_RTAKE) begin
            revData  <= data2_r;
            revValid <= 1'b1;
        end
        // Host clock falls only while strobing; high at idle [RULE1]
        hostClkOut <= !(state_nxt == ST_FSTRB); // [RULE4]
        // Open collector drives only low; push-pull drives always [RULE10]
        hostClkOe  <= ecpDrv_r | (state_nxt == ST_FSTRB);
        // Host ack low in reverse idle and stall; high to take a byte [RULE7] [RULE11]
        hostAckOut <= (state_nxt == ST_RACK); // [RULE8]
        hostAckOe  <= ecpDrv_r | (state_nxt == ST_RIDLE);
        // Data driven with the phase, released in reverse or EPP read
        dataOut    <= dataHold_r;
        dataOe     <= (state_nxt == ST_FSETUP || state_nxt == ST_FSTRB || state_nxt == ST_FREL ||
                       (state_nxt == ST_EPP && !portDirectionBit)) ? 8'hff : 8'h00;
        if (state_r == ST_FIDLE && state_nxt == ST_EPP) begin
            dataOut    <= fwdData;
            dataHold_r <= fwdData; // Write byte stands for the whole cycle
        end
        // Write line low only through an EPP write [RULE14] [RULE15]
        eppWrite_n <= !((state_nxt == ST_EPP || state_nxt == ST_EPPEND) && !portDirectionBit);
        // Ready withdrawn from strobe until wait settles or time-out [RULE16]
        hostReady  <= !(state_nxt == ST_EPP);
        if (state_r == ST_EPP && state_nxt == ST_EPPEND) begin
            eppTimeout <= waitF;
            if (portDirectionBit) begin
                revData <= data2_r;
            end
        end
    end
end

endmodule

/* dv/ppe_port_properties.sv */
/* Checker for the ppe_port handshake timing.
   Assumes a bind onto ppe_port, one mclk domain. */
`timescale 1ns/1ns
`include "ppe_consts.vh"
module ppe_port_props (
    // Clock, reset and controls
    input wire       mclk, reset_n, portDirectionBit, revFull, dmaTermCount, hostStrobe_n,
    input wire [2:0] portMode,
    // Status and cable
    input wire       revValid, hostReady, periphReqSeen, periphAckIn, periphClkIn, waitIn_n,
    input wire       hostClkOut, hostClkOe, hostAckOut, eppWrite_n,
    input wire [7:0] dataOut, dataOe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    // Forward strobe
    chk_strobe_rest: assert property (
        $rose(hostClkOut) |=> hostClkOut [*4]) else $error("strobe rest too short");
    chk_data_setup: assert property (
        $fell(hostClkOut) && portMode == `PPE_MODE_ECP |-> $past(dataOe, 4) == 8'hff && $past(dataOut, 4) == dataOut)
        else $error("data setup short");
    chk_busy_gate: assert property (
        $fell(hostClkOut) |-> !periphAckIn && !$past(periphAckIn, 8)) else $error("strobe while busy");
    // Driver style lags the mode by two cycles; that lag is kept out
    chk_oc_strobe: assert property (
        portMode != `PPE_MODE_ECP && $past(portMode) != `PPE_MODE_ECP &&
        $past(portMode, 2) != `PPE_MODE_ECP && hostClkOe |-> !hostClkOut)
        else $error("strobe driven high");
    ////////////////////////////////////////////////////////////////
    // Reverse ack
    chk_ack_stall: assert property (
        $rose(hostAckOut) |-> !$past(revFull) && !$past(dmaTermCount)) else $error("ack while stalled");
    chk_ack_filter: assert property (
        $rose(hostAckOut) |-> !$past(periphClkIn, 3) && !$past(periphClkIn, 5)) else $error("ack unfiltered");
    chk_rev_deliver: assert property (
        revValid |-> !hostAckOut && $past(hostAckOut)) else $error("byte without ack fall");
    ////////////////////////////////////////////////////////////////
    // EPP and peripheral request
    chk_ready_bound: assert property (
        $fell(hostReady) |-> ##[1:520] hostReady) else $error("ready never back");
    chk_wait_settle: assert property (
        $fell(waitIn_n) |-> !hostReady [*3]) else $error("wait not settled");
    chk_write_line: assert property (
        !eppWrite_n |-> portMode == `PPE_MODE_EPP && !portDirectionBit) else $error("write line low");
    chk_req_sticky: assert property (
        periphReqSeen |=> periphReqSeen) else $error("request lost");
endmodule
bind ppe_port ppe_port_props i_ppe_port_props (
    .mclk(mclk), .reset_n(reset_n), .portDirectionBit(portDirectionBit), .revFull(revFull),
    .dmaTermCount(dmaTermCount), .hostStrobe_n(hostStrobe_n), .portMode(portMode), .revValid(revValid),
    .hostReady(hostReady), .periphReqSeen(periphReqSeen), .periphAckIn(periphAckIn),
    .periphClkIn(periphClkIn), .waitIn_n(waitIn_n), .hostClkOut(hostClkOut), .hostClkOe(hostClkOe),
    .hostAckOut(hostAckOut), .eppWrite_n(eppWrite_n), .dataOut(dataOut), .dataOe(dataOe));

/* dv/ppe_periph_model.sv */
/* Behavioural cable peripheral for ppe_port.
   Assumes resolved wire levels from the bench, steps on mclk. */
`timescale 1ns/1ns
module ppe_periph_model (
    // Clock and cable levels
    input wire       mclk, hostClkWire, hostAckWire, hostReady, revGo, waitSlow, reqGo,
    input wire [7:0] dataWire,
    // Peripheral drives
    output reg       periphAck, periphClk, periphReq_n, waitOut_n, revDrive,
    output reg [7:0] capByte, capCount
);
    initial begin
        periphAck = 1'b0;
        periphClk = 1'b1;
        periphReq_n = 1'b1;
        waitOut_n = 1'b1;
        revDrive = 1'b0;
        capByte = 8'h00;
        capCount = 8'h00;
    end
    // Take data while strobe low, where it must be stable
    always @(negedge hostClkWire) begin
        repeat (3) @(posedge mclk);
        capByte <= dataWire;
        periphAck <= 1'b1;
        @(posedge hostClkWire);
        repeat (3) @(posedge mclk);
        capCount <= capCount + 8'h01;
        periphAck <= 1'b0;
    end
    // Reverse byte interlocked on host ack
    initial forever begin
        @(posedge mclk);
        if (revGo) begin
            while (hostAckWire) @(posedge mclk);
            revDrive <= 1'b1;
            repeat (2) @(posedge mclk);
            periphClk <= 1'b0;
            while (!hostAckWire) @(posedge mclk);
            periphClk <= 1'b1;
            while (hostAckWire) @(posedge mclk);
            revDrive <= 1'b0;
            while (revGo) @(posedge mclk);
        end
    end
    // Wait answer; silent when slow to force the time-out
    always @(negedge hostReady) begin
        if (!waitSlow) begin
            repeat (4) @(posedge mclk);
            waitOut_n <= 1'b0;
            @(posedge hostReady);
            waitOut_n <= 1'b1;
        end
    end
    // Request pulse shorter than a clock period
    always @(posedge reqGo) begin
        #7 periphReq_n = 1'b0;
        #8 periphReq_n = 1'b1;
    end
endmodule

/* dv/ppe_port_tb_top.sv */
/* Testbench for ppe_port with a cable peripheral model.
   Assumes ppe_consts.vh on the include path. */
`timescale 1ns/1ns
`include "ppe_consts.vh"
module ppe_port_tb_top;
    reg        mclk, reset_n, portDirectionBit, reverseReq, dmaTermCount, fwdValid, revFull, hostStrobe_n;
    reg        revGo, waitSlow, reqGo;
    reg  [2:0] portMode;
    reg  [7:0] fwdData, revByte, capWant;
    wire       fwdReady, revValid, hostReady, eppTimeout, periphReqSeen, hostClkOut, hostClkOe, hostAckOut;
    wire       hostAckOe, eppWrite_n, periphAck, periphClk, periphReq_n, waitOut_n, revDrive;
    wire [7:0] revData, dataOut, dataOe, capByte, capCount;
    integer    errors, samples_checked, n;
    // Pull-ups wherever nobody drives
    wire       hostClkWire = hostClkOe ? hostClkOut : 1'b1;
    wire       hostAckWire = hostAckOe ? hostAckOut : 1'b1;
    wire [7:0] dataWire = (dataOe & dataOut) | (~dataOe & (revDrive ? revByte : 8'hff));
    ppe_port i_ppe_port (.mclk(mclk), .reset_n(reset_n), .portMode(portMode), .portDirectionBit(portDirectionBit),
        .reverseReq(reverseReq), .dmaTermCount(dmaTermCount), .fwdValid(fwdValid), .fwdData(fwdData),
        .fwdReady(fwdReady), .revFull(revFull), .revValid(revValid), .revData(revData),
        .hostStrobe_n(hostStrobe_n), .hostReady(hostReady), .eppTimeout(eppTimeout),
        .periphReqSeen(periphReqSeen), .hostClkIn(hostClkWire), .hostAckIn(hostAckWire),
        .periphAckIn(periphAck), .periphClkIn(periphClk), .periphReq_n(periphReq_n), .waitIn_n(waitOut_n),
        .dataIn(dataWire), .hostClkOut(hostClkOut), .hostClkOe(hostClkOe), .hostAckOut(hostAckOut),
        .hostAckOe(hostAckOe), .dataOut(dataOut), .dataOe(dataOe), .eppWrite_n(eppWrite_n));
    ppe_periph_model i_ppe_periph_model (.mclk(mclk), .hostClkWire(hostClkWire), .hostAckWire(hostAckWire),
        .hostReady(hostReady), .revGo(revGo), .waitSlow(waitSlow), .reqGo(reqGo), .dataWire(dataWire),
        .periphAck(periphAck), .periphClk(periphClk), .periphReq_n(periphReq_n), .waitOut_n(waitOut_n),
        .revDrive(revDrive), .capByte(capByte), .capCount(capCount));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        samples_checked = samples_checked + 1;
        if (ok !== 1'b1) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask
    task tick(input integer k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // One bounded wait serves fwdReady, revValid, hostReady, hostAckWire and capCount
    function logic pick(input integer sel);
        case (sel)
            0: pick = fwdReady;
            1: pick = revValid;
            2: pick = hostReady;
            3: pick = hostAckWire;
            default: pick = (capCount === capWant);
        endcase
    endfunction
    task await(input integer sel, input logic v);
        for (n = 0; pick(sel) !== v && n < 700; n = n + 1) tick(1);
        if (n == 700) begin
            chk(1'b0, "wait timed out");
            final_report;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task t_forward(input [2:0] mode, input [7:0] b0, input [7:0] b1);
        @(posedge mclk);
        portMode <= mode;
        tick(8);
        capWant = capCount + 8'h01;
        @(posedge mclk);
        fwdValid <= 1'b1;
        fwdData <= b0;
        await(0, 1'b1);
        @(posedge mclk);
        fwdData <= b1;
        await(4, 1'b1);
        chk(capByte === b0, "first forward byte");
        capWant = capCount + 8'h01;
        await(0, 1'b1);
        @(posedge mclk);
        fwdValid <= 1'b0;
        await(4, 1'b1);
        chk(capByte === b1, "second forward byte");
        $display("forward mode %0d done", mode);
    endtask
    task t_epp(input logic dir, input logic slow);
        @(posedge mclk);
        portMode <= `PPE_MODE_EPP;
        portDirectionBit <= dir;
        waitSlow <= slow;
        fwdData <= 8'h6e;
        tick(4);
        @(posedge mclk);
        hostStrobe_n <= 1'b0;
        tick(2);
        chk(hostReady === 1'b0, "ready not withdrawn");
        chk(eppWrite_n === dir, "write line level");
        chk(dataWire === (dir ? 8'hff : 8'h6e), "epp data direction");
        await(2, 1'b1);
        chk((n > 480) === slow, "wait or time-out length");
        @(posedge mclk);
        hostStrobe_n <= 1'b1;
        tick(3);
        chk(eppTimeout === slow, "time-out flag");
        chk(eppWrite_n === 1'b1, "write line idle");
        chk(!dir || revData === 8'hff, "epp read byte");
        $display("epp dir %0d slow %0d done", dir, slow);
    endtask
    task t_reverse;
        @(posedge mclk);
        portMode <= `PPE_MODE_ECP;
        dmaTermCount <= 1'b1;
        reverseReq <= 1'b1;
        await(3, 1'b0);
        revByte <= 8'ha5;
        revGo <= 1'b1;
        tick(30);
        chk(hostAckOut === 1'b0, "ack on terminal count");
        @(posedge mclk);
        dmaTermCount <= 1'b0;
        revFull <= 1'b1;
        tick(30);
        chk(hostAckOut === 1'b0, "ack while full");
        @(posedge mclk);
        revFull <= 1'b0;
        await(1, 1'b1);
        chk(revData === 8'ha5, "reverse byte");
        @(posedge mclk);
        revGo <= 1'b0;
        tick(3);
        @(posedge mclk);
        revByte <= 8'h3c;
        revGo <= 1'b1;
        await(1, 1'b1);
        chk(revData === 8'h3c, "second reverse byte");
        $display("reverse done");
    endtask
    task t_request;
        chk(periphReqSeen === 1'b0, "request seen early");
        @(posedge mclk);
        reqGo <= 1'b1;
        tick(6);
        chk(periphReqSeen === 1'b1, "short request missed");
        $display("request done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {errors, samples_checked, n} = 0;
        {reset_n, portDirectionBit, reverseReq, dmaTermCount, fwdValid, revFull, revGo, waitSlow, reqGo} = 0;
        {hostStrobe_n, portMode, fwdData, revByte, capWant} = {1'b1, `PPE_MODE_ECP, 24'h0};
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        tick(8);
        chk(hostClkOut === 1'b1, "strobe low after reset");
        chk(eppWrite_n === 1'b1, "write line low after reset");
        t_forward(`PPE_MODE_ECP, 8'h5a, 8'h81);
        t_request;
        t_forward(`PPE_MODE_FIFO, 8'hc3, 8'h00);
        t_forward(`PPE_MODE_FIFO_DOC, 8'hff, 8'h24);
        t_epp(1'b0, 1'b0);
        t_epp(1'b1, 1'b0);
        t_epp(1'b0, 1'b1);
        t_reverse;
        final_report;
    end
endmodule
